// [core/cycle_dcache_iprs.sv]
// Cycle counter, alternate mode and data cache test register group
// Contract
// R1: Any invalidate write clears all valid bits in both cache banks.
// R2: Alternate mode field bits 4:3 select kernel, executive, supervisor or user.
// R3: When enabled, low 32 counter bits increment each clock; upper half holds.
// R4: Counter register write updates only bits 63:32.
// R5: Read cycle count returns full 64-bit counter.
// R6: Counting starts three cycles after enabling control write.
// R7: Reset leaves counter disabled.
// R8: Control write loads bits 31:4, zeroes 3:0, keeps 63:32.
// R9: Control bit 32 enables or disables counting on each control write.
// R10: Test control bits 12:3 hold ten-bit tag index.
// R11: Bit 0 steers reads to bank 0, else bank 1; enables bank 0 writes.
// R12: Bit 1 enables bank 1 writes only, never affects reads.
// R13: Bit 13 drives serial repair data level.
// R14: Writing one to bit 14 gives a one-cycle shift pulse; reads zero.
// R15: Software shifts repair data one bit per shift write.
// R16: Bit 15 selects scanned data over fuses; cleared by reset.
// R17: Software follows repair writes with a memory barrier.
// R18: Tag write updates every bank whose write enable is set.
// R19: Alternate mode bits outside the field are ignored.
// R20: Reads of write-only registers disturb nothing.
`timescale 1ns/1ps
module cycle_dcache_iprs
	import iprs_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Register move port
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [9:0] i_ipr_idx,
	input wire logic [63:0] i_wr_data,
	output logic [63:0] o_rd_data,
	output logic o_rd_valid,
	// Read cycle count instruction
	input wire logic i_read_cycle_count_instruction,
	output logic [63:0] o_cycle_count,
	// Alternate mode to load/store unit
	output logic [1:0] o_alternate_mode_select,
	// Data cache control
	output logic o_dcache_invalidate,
	output logic [9:0] o_tag_index,
	output logic o_tag_rd_first_bank_select,
	output logic o_tag_wr_first_bank_select,
	output logic o_tag_wr_second_bank_write_enable,
	output logic o_tag_wr_pulse,
	output logic o_tag_rd_pulse,
	output logic o_repair_data,
	output logic o_repair_shift,
	output logic o_repair_load
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic wr_mode;
	logic wr_cc;
	logic wr_ctl;
	logic wr_inv;
	logic wr_test;
	logic wr_tag;
	logic rd_tag;
	logic counting;

	assign wr_mode = i_wr_en && (i_ipr_idx == alternate_mode_select_idx);
	assign wr_cc = i_wr_en && (i_ipr_idx == cycle_counter_value_idx);
	assign wr_ctl = i_wr_en && (i_ipr_idx == cycle_counter_control_idx);
	assign wr_inv = i_wr_en && (i_ipr_idx == data_cache_invalidate_all_idx);
	assign wr_test = i_wr_en && (i_ipr_idx == data_cache_test_control_idx);
	assign wr_tag = i_wr_en && (i_ipr_idx == data_cache_diag_tag_port_idx);
	assign rd_tag = i_rd_en && (i_ipr_idx == data_cache_diag_tag_port_idx);

	// ----------------------------------------
	// Counter enable pipeline
	// ----------------------------------------
	enable_delay u_enable_delay (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_write(wr_ctl),
		.i_enable(i_wr_data[counter_enable_bit]), // R9
		.o_counting(counting)
	);

	// ----------------------------------------
	// Cycle counter
	// ----------------------------------------
	logic [31:0] cc_offset_r;
	logic [31:0] cc_offset_nxt;
	logic [31:0] cc_count_r;
	logic [31:0] cc_count_nxt;

	always_comb begin
		cc_offset_nxt = cc_offset_r;
		cc_count_nxt = cc_count_r;
		if (counting) begin
			cc_count_nxt = cc_count_r + 32'h1; // R3
		end
		if (wr_cc) begin
			cc_offset_nxt = i_wr_data[63:offset_lo]; // R4
		end
		if (wr_ctl) begin
			cc_count_nxt = {i_wr_data[count_hi:count_lo], 4'h0}; // R8
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			cc_offset_r <= 32'h0;
			cc_count_r <= 32'h0;
		end else begin
			cc_offset_r <= cc_offset_nxt;
			cc_count_r <= cc_count_nxt;
		end
	end

	// ----------------------------------------
	// Mode and test control
	// ----------------------------------------
	alternate_mode_select_t mode_r;
	alternate_mode_select_t mode_nxt;
	logic [15:0] test_r;
	logic [15:0] test_nxt;
	logic shift_r;
	logic shift_nxt;
	logic inv_r;
	logic inv_nxt;
	logic tag_wr_r;
	logic tag_wr_nxt;
	logic tag_rd_r;
	logic tag_rd_nxt;

	always_comb begin
		mode_nxt = mode_r;
		test_nxt = test_r;
		// Only the two mode bits are kept
		if (wr_mode) begin
			mode_nxt = alternate_mode_select_t'(i_wr_data[mode_hi:mode_lo]); // R2 R19
		end
		if (wr_test) begin
			test_nxt = i_wr_data[15:0]; // R10
			test_nxt[repair_shift_bit] = 1'b0; // R14
		end
		shift_nxt = wr_test && i_wr_data[repair_shift_bit]; // R14
		inv_nxt = wr_inv; // R1
		tag_wr_nxt = wr_tag; // R18
		tag_rd_nxt = rd_tag;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			mode_r <= mode_kernel;
			test_r <= test_ctl_reset; // R16
			shift_r <= 1'b0;
			inv_r <= 1'b0;
			tag_wr_r <= 1'b0;
			tag_rd_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			test_r <= test_nxt;
			shift_r <= shift_nxt;
			inv_r <= inv_nxt;
			tag_wr_r <= tag_wr_nxt;
			tag_rd_r <= tag_rd_nxt;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [63:0] rd_data_r;
	logic [63:0] rd_data_nxt;
	logic rd_valid_r;
	logic [63:0] read_cycle_count_instruction_r;
	logic [63:0] read_cycle_count_instruction_nxt;

	always_comb begin
		// Write-only registers and the tag port return zero; a tag port read also pulses o_tag_rd_pulse
		rd_data_nxt = 64'h0; // R20
		if (i_ipr_idx == cycle_counter_value_idx) begin
			rd_data_nxt = {cc_offset_r, cc_count_r}; // R5
		end else if (i_ipr_idx == data_cache_test_control_idx) begin
			rd_data_nxt = {48'h0, test_r};
		end
		read_cycle_count_instruction_nxt = i_read_cycle_count_instruction ? {cc_offset_r, cc_count_r} : read_cycle_count_instruction_r; // R5
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rd_data_r <= 64'h0;
			rd_valid_r <= 1'b0;
			read_cycle_count_instruction_r <= 64'h0;
		end else begin
			rd_data_r <= i_rd_en ? rd_data_nxt : rd_data_r;
			rd_valid_r <= i_rd_en;
			read_cycle_count_instruction_r <= read_cycle_count_instruction_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rd_data = rd_data_r;
	assign o_rd_valid = rd_valid_r;
	assign o_cycle_count = read_cycle_count_instruction_r;
	assign o_alternate_mode_select = mode_r;
	assign o_dcache_invalidate = inv_r; // R1
	assign o_tag_index = test_r[index_hi:index_lo]; // R10
	assign o_tag_rd_first_bank_select = test_r[first_bank_select]; // R11
	assign o_tag_wr_first_bank_select = test_r[first_bank_select]; // R11
	assign o_tag_wr_second_bank_write_enable = test_r[second_bank_write_enable]; // R12
	assign o_tag_wr_pulse = tag_wr_r; // R18
	assign o_tag_rd_pulse = tag_rd_r;
	assign o_repair_data = test_r[repair_data_bit]; // R13
	assign o_repair_shift = shift_r; // R14
	assign o_repair_load = test_r[repair_load_bit]; // R16
endmodule : cycle_dcache_iprs

// [core/enable_delay.sv]
// Delayed enable for the cycle counter
`timescale 1ns/1ps
module enable_delay
	import iprs_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Control
	input wire logic i_write,
	input wire logic i_enable,
	// State
	output logic o_counting
);
	logic [1:0] wait_r;
	logic [1:0] wait_nxt;
	logic counting_r;
	logic counting_nxt;
	logic arm_r;
	logic arm_nxt;

	always_comb begin
		wait_nxt = wait_r;
		counting_nxt = counting_r;
		arm_nxt = arm_r;
		if (i_write) begin
			// Disable is immediate; enable waits out the pipeline
			counting_nxt = 1'b0;
			arm_nxt = i_enable;
			wait_nxt = enable_delay_load;
		end else if (arm_r) begin
			if (wait_r == 2'h1) begin
				counting_nxt = 1'b1; // R6
				arm_nxt = 1'b0;
			end
			wait_nxt = wait_r - 2'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			wait_r <= 2'h0;
			counting_r <= 1'b0; // R7
			arm_r <= 1'b0;
		end else begin
			wait_r <= wait_nxt;
			counting_r <= counting_nxt;
			arm_r <= arm_nxt;
		end
	end

	assign o_counting = counting_r;
endmodule : enable_delay

// [core/iprs_pkg.sv]
// Constants for the cycle counter and data cache test register group
package iprs_pkg;
	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [9:0] alternate_mode_select_idx = 10'h20c;
	localparam logic [9:0] cycle_counter_value_idx = 10'h20d;
	localparam logic [9:0] cycle_counter_control_idx = 10'h20e;
	localparam logic [9:0] data_cache_invalidate_all_idx = 10'h210;
	localparam logic [9:0] data_cache_test_control_idx = 10'h213;
	localparam logic [9:0] data_cache_diag_tag_port_idx = 10'h214;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int mode_lo = 3;
	localparam int mode_hi = 4;
	localparam int count_lo = 4;
	localparam int count_hi = 31;
	localparam int offset_lo = 32;
	localparam int counter_enable_bit = 32;
	localparam int first_bank_select = 0;
	localparam int second_bank_write_enable = 1;
	localparam int index_lo = 3;
	localparam int index_hi = 12;
	localparam int repair_data_bit = 13;
	localparam int repair_shift_bit = 14;
	localparam int repair_load_bit = 15;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [1:0] mode_reset = 2'h0;
	localparam logic [15:0] test_ctl_reset = 16'h0000;
	localparam int enable_delay_cycles = 3;
	localparam logic [1:0] enable_delay_load = 2'(enable_delay_cycles - 1);
	typedef enum logic [1:0] {
		mode_kernel = 2'h0,
		mode_executive = 2'h1,
		mode_supervisor = 2'h2,
		mode_user = 2'h3
	} alternate_mode_select_t;
endpackage : iprs_pkg

// [dv/iprs_monitor.sv]
// Checker for the register group outputs
`timescale 1ns/1ps
module iprs_monitor
	import iprs_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Register move port
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [9:0] i_ipr_idx,
	input wire logic [63:0] i_wr_data,
	// Observed outputs
	input wire logic [1:0] o_alternate_mode_select,
	input wire logic o_dcache_invalidate,
	input wire logic [9:0] o_tag_index,
	input wire logic o_tag_rd_first_bank_select,
	input wire logic o_tag_wr_second_bank_write_enable,
	input wire logic o_repair_data,
	input wire logic o_repair_shift,
	input wire logic o_repair_load,
	input wire logic o_tag_wr_first_bank_select,
	input wire logic o_tag_wr_pulse,
	input wire logic o_tag_rd_pulse,
	input wire logic o_rd_valid
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	logic inv_w;
	logic mode_w;
	logic tc_w;
	logic sh_w;
	logic tag_w;
	logic tag_r;
	assign inv_w = i_wr_en && i_ipr_idx == data_cache_invalidate_all_idx;
	assign mode_w = i_wr_en && i_ipr_idx == alternate_mode_select_idx;
	assign tc_w = i_wr_en && i_ipr_idx == data_cache_test_control_idx;
	assign sh_w = tc_w && i_wr_data[repair_shift_bit];
	assign tag_w = i_wr_en && i_ipr_idx == data_cache_diag_tag_port_idx;
	assign tag_r = i_rd_en && i_ipr_idx == data_cache_diag_tag_port_idx;
	property p_inv; inv_w |=> o_dcache_invalidate; endproperty
	a_inv: assert property (p_inv) else $error("invalidate pulse missing");
	property p_inv_cause; o_dcache_invalidate |-> $past(inv_w); endproperty
	a_inv_cause: assert property (p_inv_cause) else $error("stray invalidate");
	property p_mode; mode_w |=> o_alternate_mode_select == $past(i_wr_data[4:3]); endproperty
	a_mode: assert property (p_mode) else $error("mode field wrong");
	property p_mode_hold; !mode_w |=> $stable(o_alternate_mode_select); endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
	// Back-to-back shift writes legally give back-to-back pulses
	property p_shift;
		sh_w |=> o_repair_shift ##1 (!o_repair_shift || $past(sh_w));
	endproperty
	a_shift: assert property (p_shift) else $error("shift pulse wrong");
	property p_shift_cause; o_repair_shift |-> $past(sh_w); endproperty
	a_shift_cause: assert property (p_shift_cause) else $error("stray shift pulse");
	property p_index;
		tc_w |=> o_tag_index == $past(i_wr_data[12:3]) && o_tag_rd_first_bank_select == $past(i_wr_data[0]);
	endproperty
	a_index: assert property (p_index) else $error("index or bank wrong");
	property p_second_bank_write_enable; tc_w |=> o_tag_wr_second_bank_write_enable == $past(i_wr_data[1]); endproperty
	a_second_bank_write_enable: assert property (p_second_bank_write_enable) else $error("second_bank_write_enable enable wrong");
	property p_repair;
		tc_w |=> o_repair_data == $past(i_wr_data[13]) && o_repair_load == $past(i_wr_data[15]);
	endproperty
	a_repair: assert property (p_repair) else $error("repair level wrong");
	property p_first_bank_select; tc_w |=> o_tag_wr_first_bank_select == $past(i_wr_data[0]); endproperty
	a_first_bank_select: assert property (p_first_bank_select) else $error("first_bank_select write enable wrong");
	property p_tag_wr; tag_w |=> o_tag_wr_pulse; endproperty
	a_tag_wr: assert property (p_tag_wr) else $error("tag write pulse missing");
	property p_tag_wr_cause; o_tag_wr_pulse |-> $past(tag_w); endproperty
	a_tag_wr_cause: assert property (p_tag_wr_cause) else $error("stray tag write");
	property p_tag_rd; tag_r |=> o_tag_rd_pulse; endproperty
	a_tag_rd: assert property (p_tag_rd) else $error("tag read pulse missing");
	property p_rd_valid; i_rd_en |=> o_rd_valid; endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
endmodule : iprs_monitor

// [dv/testbench.sv]
// Self-checking bench for the register group
`timescale 1ns/1ps
module testbench;
	import iprs_pkg::*;
	logic i_mclk, i_srst, i_wr_en, i_rd_en, i_read_cycle_count_instruction, o_rd_valid, o_dcache_invalidate;
	logic o_tag_rd_first_bank_select, o_tag_wr_first_bank_select, o_tag_wr_second_bank_write_enable, o_tag_wr_pulse, o_tag_rd_pulse;
	logic o_repair_data, o_repair_shift, o_repair_load;
	logic [1:0] o_alternate_mode_select;
	logic [2:0] pl;
	logic [9:0] i_ipr_idx, o_tag_index;
	logic [63:0] i_wr_data, o_rd_data, o_cycle_count;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	cycle_dcache_iprs i_dut (.i_mclk, .i_srst, .i_wr_en, .i_rd_en, .i_ipr_idx, .i_wr_data,
		.o_rd_data, .o_rd_valid, .i_read_cycle_count_instruction, .o_cycle_count, .o_alternate_mode_select, .o_dcache_invalidate,
		.o_tag_index, .o_tag_rd_first_bank_select, .o_tag_wr_first_bank_select, .o_tag_wr_second_bank_write_enable, .o_tag_wr_pulse,
		.o_tag_rd_pulse, .o_repair_data, .o_repair_shift, .o_repair_load);
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [63:0] d);
		i_ipr_idx = a;
		i_wr_data = d;
		i_wr_en = 1'b1;
		@(negedge i_mclk);
		i_wr_en = 1'b0;
		// Pulses last one cycle, so grab them here
		pl = {o_repair_shift, o_dcache_invalidate, o_tag_wr_pulse};
		@(negedge i_mclk);
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [63:0] e);
		i_ipr_idx = a;
		i_rd_en = 1'b1;
		@(negedge i_mclk);
		i_rd_en = 1'b0;
		pl = {2'h0, o_tag_rd_pulse};
		chk(64'(o_rd_valid), 64'h1);
		chk(o_rd_data, e);
		@(negedge i_mclk);
	endtask : rd
	task automatic read_cycle_count_instruction(input logic [63:0] e);
		i_read_cycle_count_instruction = 1'b1;
		@(negedge i_mclk);
		i_read_cycle_count_instruction = 1'b0;
		chk(o_cycle_count, e);
		@(negedge i_mclk);
	endtask : read_cycle_count_instruction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	// Run is under 200 cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{i_srst, i_wr_en, i_rd_en, i_read_cycle_count_instruction, i_ipr_idx, i_wr_data} = {1'b1, 77'h0};
		repeat (10) @(negedge i_mclk);
		i_srst = 1'b0;
		repeat (4) @(negedge i_mclk);
		read_cycle_count_instruction(64'h0);
		wr(cycle_counter_control_idx, 64'h1_8765_432f);
		repeat (2) @(negedge i_mclk);
		read_cycle_count_instruction(64'h8765_4321);
		read_cycle_count_instruction(64'h8765_4323);
		wr(cycle_counter_control_idx, 64'h0_0000_01ff);
		wr(cycle_counter_value_idx, 64'hcafe_f00d_1111_1111);
		read_cycle_count_instruction(64'hcafe_f00d_0000_01f0);
		rd(cycle_counter_value_idx, 64'hcafe_f00d_0000_01f0);
		for (int m = 0; m < 4; m++) begin
			wr(alternate_mode_select_idx, 64'hffff_ffe7 | (64'(m) << 3));
			chk(64'(o_alternate_mode_select), 64'(m));
		end
		rd(alternate_mode_select_idx, 64'h0);
		chk(64'(o_alternate_mode_select), 64'h3);
		wr(data_cache_invalidate_all_idx, '1);
		chk(64'(pl), 64'h2);
		wr(data_cache_test_control_idx, 64'hf529);
		chk(64'(pl), 64'h4);
		chk(64'({o_repair_load, o_repair_data, o_tag_index}), 64'hea5);
		chk(64'({o_tag_wr_second_bank_write_enable, o_tag_wr_first_bank_select, o_tag_rd_first_bank_select}), 64'h3);
		rd(data_cache_test_control_idx, 64'hb529);
		wr(data_cache_test_control_idx, 64'h2ad2);
		chk(64'({o_repair_load, o_tag_wr_second_bank_write_enable, o_tag_wr_first_bank_select, o_tag_rd_first_bank_select}), 64'h4);
		wr(data_cache_diag_tag_port_idx, 64'h5);
		chk(64'(pl), 64'h1);
		rd(10'h3ff, 64'h0);
		rd(data_cache_diag_tag_port_idx, 64'h0);
		chk(64'(pl), 64'h1);
		for (int b = 0; b < 2; b++) begin
			wr(data_cache_test_control_idx, 64'h4000 | (64'(b) << repair_data_bit));
			chk(64'({pl, o_repair_data}), 64'h8 | 64'(b));
		end
		wr(data_cache_test_control_idx, 64'h8000);
		chk(64'(o_repair_load), 64'h1);
		wr(cycle_counter_control_idx, 64'h1_0000_0000);
		// Mid-run reset while the enable is still in its pipeline
		i_srst = 1'b1;
		repeat (2) @(negedge i_mclk);
		i_srst = 1'b0;
		chk(64'(o_repair_load), 64'h0);
		repeat (4) @(negedge i_mclk);
		read_cycle_count_instruction(64'h0);
		tally_and_finish();
	end
endmodule : testbench
bind cycle_dcache_iprs iprs_monitor i_mon (.i_mclk, .i_srst, .i_wr_en, .i_rd_en, .i_ipr_idx,
	.i_wr_data, .o_alternate_mode_select, .o_dcache_invalidate, .o_tag_index, .o_tag_rd_first_bank_select,
	.o_tag_wr_second_bank_write_enable, .o_repair_data, .o_repair_shift, .o_repair_load, .o_tag_wr_first_bank_select,
	.o_tag_wr_pulse, .o_tag_rd_pulse, .o_rd_valid);
